/* File: morx_exec.sv */
// Execution datapath for OR, return and left-rotate instructions
// Notes on behaviour
// RULE1 - OR immediate into accumulator, zero flag only
// RULE2 - OR accumulator into memory, accumulator kept
// RULE3 - Subroutine exit pops PC, flags unchanged
// RULE4 - Exit with immediate pops PC, loads accumulator
// RULE5 - Interrupt exit pops PC, sets master enable
// RULE6 - Pending interrupt serviced before resuming main
// RULE7 - Memory rotate left, bit7 into bit0
// RULE8 - Rotate left into accumulator, memory kept
// RULE9 - Zero flag set when OR result zero
`include "morx_regs.svh"
`default_nettype none
module morx_exec
  import morx_pkg::*;
(
  input  wire logic                    CLK,         // Core clock
  input  wire logic                    RESETN,      // Async reset, low
  input  wire logic                    INSTR_VALID, // Instruction issued this cycle
  input  wire morx_instr_t             INSTR,       // Decoded instruction
  input  wire logic [`MORX_DW-1:0]     MEM_RDATA,   // Addressed memory byte
  input  wire logic [`MORX_PCW-1:0]    STACK_TOP,   // Top of return stack
  input  wire logic                    IRQ_PENDING, // Interrupt request waiting
  input  wire logic                    IRQ_ENABLE_CLEAR, // Core clears enable on entry
  output var  logic [`MORX_DW-1:0]     ACC,         // Accumulator
  output var  logic                    ZERO,        // Zero flag
  output var  logic [`MORX_PCW-1:0]    PC,          // Program counter
  output var  logic                    STACK_POP,   // Pop strobe
  output var  logic                    STACK_PUSH,  // Push strobe for vectoring
  output var  logic [`MORX_PCW-1:0]    PUSH_DATA,   // Address pushed
  output var  morx_memwr_t             MEM_WR,      // Memory write-back
  output var  logic                    MASTER_IRQ_ENABLE // Global interrupt enable
);
  // Registers
  logic [`MORX_DW-1:0]  acc_q, acc_d;          // Accumulator
  logic                 zero_q, zero_d;        // Zero flag
  logic [`MORX_PCW-1:0] pc_q, pc_d;            // Program counter
  logic                 pop_q, push_q;         // Stack strobes
  logic [`MORX_PCW-1:0] push_data_q;           // Stacked return address
  morx_memwr_t          memwr_q, memwr_d;      // Write-back
  logic                 mie_q, mie_d;          // Master enable
  morx_state_t          state_q;               // Vectoring state

  // Rotate helper, used for both rotate forms
  // Kept as one function so both rotates can never drift apart
  function automatic logic [7:0] morx_rotl(input logic [7:0] v);
    morx_rotl = {v[6:0], v[`MORX_MSB]};
  endfunction : morx_rotl

  // Decode wires; nothing is taken in the vector bubble
  wire is_op           = INSTR_VALID && (state_q == MORX_ST_RUN);
  wire op_or_imm       = is_op && INSTR.op == MORX_OP_OR_IMM;
  wire op_or_mem       = is_op && INSTR.op == MORX_OP_OR_TO_MEMORY;
  wire op_sub_exit     = is_op && INSTR.op == MORX_OP_SUBROUTINE_EXIT;
  wire op_sub_exit_imm = is_op && INSTR.op == MORX_OP_SUBROUTINE_EXIT_IMM;
  wire op_int_exit     = is_op && INSTR.op == MORX_OP_INTERRUPT_EXIT;
  wire op_mem_rot      = is_op && INSTR.op == MORX_OP_MEMORY_LEFT_ROTATE;
  wire op_acc_rot      = is_op && INSTR.op == MORX_OP_LEFT_ROTATE_TO_WORKING_REG;
  wire any_pop         = op_sub_exit || op_sub_exit_imm || op_int_exit;
  wire or_any          = op_or_imm || op_or_mem;   // Only writers of the zero flag

  // Results
  wire [7:0] or_imm_res = acc_q | INSTR.imm;   // [RULE1]
  wire [7:0] or_mem_res = acc_q | MEM_RDATA;   // [RULE2]
  wire [7:0] rot_res    = morx_rotl(MEM_RDATA); // [RULE7] [RULE8]

  // Pending request taken right after an interrupt exit
  wire vector_now = op_int_exit && IRQ_PENDING; // [RULE6]

  // Accumulator and zero flag next values
  // Returns and rotates leave the zero flag alone by falling through
  always_comb begin
    acc_d  = acc_q;
    zero_d = zero_q;
    if (op_or_imm) begin
      acc_d  = or_imm_res;                     // [RULE1]
      zero_d = (or_imm_res == 8'h00);          // [RULE9]
    end else if (op_or_mem) begin
      zero_d = (or_mem_res == 8'h00);          // [RULE2] [RULE9]
    end else if (op_sub_exit_imm) begin
      acc_d = INSTR.imm;                       // [RULE4]
    end else if (op_acc_rot) begin
      acc_d = rot_res;                         // [RULE8]
    end
  end

  // Memory write-back only for in-memory results
  // The accumulator rotate never raises the strobe, so memory is kept
  always_comb begin
    memwr_d = '0;
    if (op_or_mem) begin
      memwr_d = '{we: 1'b1, addr: INSTR.addr, data: or_mem_res}; // [RULE2]
    end else if (op_mem_rot) begin
      memwr_d = '{we: 1'b1, addr: INSTR.addr, data: rot_res};    // [RULE7]
    end
  end

  // Program counter: pop, or vector with stacked return
  // Vector wins over the pop: the popped address is pushed back, so
  // the handler's own exit resumes the main program later
  always_comb begin
    pc_d = pc_q;
    if (vector_now) begin
      pc_d = `MORX_IRQ_VEC;                    // [RULE6]
    end else if (any_pop) begin
      pc_d = STACK_TOP;                        // [RULE3] [RULE4] [RULE5]
    end else if (is_op) begin
      pc_d = pc_q + 11'h001;                   // Sequential fetch
    end
  end

  // Master enable; set wins over a same-cycle clear
  // A vectored exit keeps it low until the handler's own exit
  always_comb begin
    mie_d = mie_q;
    if (IRQ_ENABLE_CLEAR || vector_now) begin
      mie_d = 1'b0;                            // Entry disables nesting
    end
    if (op_int_exit && !vector_now) begin
      mie_d = 1'b1;                            // [RULE5]
    end
  end

  // Architectural registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc_q       <= `MORX_ACC_RST;
      zero_q      <= 1'b0;
      pc_q        <= `MORX_PC_RST;
      memwr_q     <= '0;
      mie_q       <= 1'b0;
      pop_q       <= 1'b0;
      push_q      <= 1'b0;
      push_data_q <= `MORX_PC_RST;
    end else begin
      acc_q       <= acc_d;
      zero_q      <= zero_d;
      pc_q        <= pc_d;
      memwr_q     <= memwr_d;
      mie_q       <= mie_d;
      pop_q       <= any_pop;
      push_q      <= vector_now;               // [RULE6]
      push_data_q <= STACK_TOP;                // Restored main address
    end
  end

  // Vectoring state: one bubble while the handler is entered
  // Limitation: an instruction offered in the bubble is dropped, the
  // core has to present it again
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= MORX_ST_RUN;
    end else begin
      case (state_q)
        MORX_ST_RUN:    state_q <= vector_now ? MORX_ST_VECTOR : MORX_ST_RUN;
        MORX_ST_VECTOR: state_q <= MORX_ST_RUN;
        default:        state_q <= MORX_ST_RUN;
      endcase
    end
  end

  // Outputs straight from flops
  assign ACC               = acc_q;
  assign ZERO              = zero_q;
  assign PC                = pc_q;
  assign STACK_POP         = pop_q;
  assign STACK_PUSH        = push_q;
  assign PUSH_DATA         = push_data_q;
  assign MEM_WR            = memwr_q;
  assign MASTER_IRQ_ENABLE = mie_q;

  // Checks: every result shows one cycle after the instruction is taken

  // OR forms
  a_or_imm_result: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE1]
    op_or_imm |=> ACC == ($past(acc_q) | $past(INSTR.imm))) else $error("OR imm wrong");
  a_or_mem_write: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE2]
    op_or_mem |=> MEM_WR.we && MEM_WR.data == ($past(acc_q) | $past(MEM_RDATA)) && $stable(ACC))
    else $error("OR mem wrong");
  a_zero_flag: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE9]
    or_any |=> ZERO == ($past(op_or_imm) ? (ACC == 8'h00) : (MEM_WR.data == 8'h00)))
    else $error("Zero flag wrong");
  a_zero_kept: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE3] [RULE5] [RULE7]
    (is_op && !or_any) |=> $stable(ZERO)) else $error("Zero flag disturbed");

  // Returns
  a_sub_exit_pc: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE3]
    op_sub_exit |=> PC == $past(STACK_TOP) && STACK_POP && $stable(ZERO)) else $error("Return wrong");
  a_exit_imm_acc: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE4]
    op_sub_exit_imm |=> ACC == $past(INSTR.imm) && PC == $past(STACK_TOP) && $stable(ZERO))
    else $error("Return imm wrong");
  a_int_exit_enable: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE5]
    (op_int_exit && !IRQ_PENDING) |=> MASTER_IRQ_ENABLE && PC == $past(STACK_TOP)) else $error("Int exit wrong");
  a_int_exit_pending: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE6]
    vector_now |=> PC == `MORX_IRQ_VEC && STACK_PUSH && PUSH_DATA == $past(STACK_TOP) && !MASTER_IRQ_ENABLE)
    else $error("Pending irq missed");
  a_bubble_hold: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE6]
    (state_q == MORX_ST_VECTOR) |=> $stable(PC) && !STACK_POP && !MEM_WR.we && $stable(ACC))
    else $error("Bubble not ignored");

  // Rotates
  a_mem_rot_write: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE7]
    op_mem_rot |=> MEM_WR.we && MEM_WR.data == {$past(MEM_RDATA[6:0]), $past(MEM_RDATA[7])} && $stable(ZERO))
    else $error("Rotate mem wrong");
  a_acc_rot_result: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE8]
    op_acc_rot |=> !MEM_WR.we && ACC == {$past(MEM_RDATA[6:0]), $past(MEM_RDATA[7])} && $stable(ZERO))
    else $error("Rotate acc wrong");
  a_write_source: assert property (@(posedge CLK) disable iff (!RESETN) // [RULE2] [RULE7] [RULE8]
    MEM_WR.we |-> $past(op_or_mem || op_mem_rot)) else $error("Stray memory write");

  // Main scenarios
  c_or_zero:   cover property (@(posedge CLK) disable iff (!RESETN) op_or_imm ##1 ZERO);
  c_vector:    cover property (@(posedge CLK) disable iff (!RESETN) vector_now);
  c_int_exit:  cover property (@(posedge CLK) disable iff (!RESETN) op_int_exit && !IRQ_PENDING);
  c_rotate:    cover property (@(posedge CLK) disable iff (!RESETN) op_mem_rot ##1 op_acc_rot);
endmodule : morx_exec
`default_nettype wire

/* File: morx_pkg.sv */
// Types for the OR, return and rotate execution block
`default_nettype none
package morx_pkg;
  // Operation selector presented by the decoder
  typedef enum logic [2:0] {
    MORX_OP_NONE,
    MORX_OP_OR_IMM,
    MORX_OP_OR_TO_MEMORY,
    MORX_OP_SUBROUTINE_EXIT,
    MORX_OP_SUBROUTINE_EXIT_IMM,
    MORX_OP_INTERRUPT_EXIT,
    MORX_OP_MEMORY_LEFT_ROTATE,
    MORX_OP_LEFT_ROTATE_TO_WORKING_REG
  } morx_op_t;
  // One issued instruction
  typedef struct packed {
    morx_op_t    op;
    logic [7:0]  imm;
    logic [6:0]  addr;
  } morx_instr_t;
  // Memory write-back request
  typedef struct packed {
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  data;
  } morx_memwr_t;
  // Execution state
  typedef enum logic [1:0] {
    MORX_ST_RUN,
    MORX_ST_VECTOR
  } morx_state_t;
endpackage : morx_pkg
`default_nettype wire

/* File: morx_regs.svh */
// Constants for the OR, return and rotate execution block
`ifndef MORX_REGS_SVH
`define MORX_REGS_SVH
`define MORX_DW        8
`define MORX_PCW       11
`define MORX_AW        7
`define MORX_ACC_RST   8'h00
`define MORX_PC_RST    11'h000
`define MORX_IRQ_VEC   11'h004
`define MORX_MSB       7
`endif

/* File: test_mcu_or_return_rotate_exec.sv */
// Self-checking bench for the OR, return and rotate execution block
`include "morx_regs.svh"
`default_nettype none
module test_mcu_or_return_rotate_exec import morx_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // Expected outputs one cycle after issue
  typedef struct {
    logic [7:0]  acc;
    logic        zero;
    logic [10:0] pc;
    logic        pop;
    logic        push;
    logic [10:0] pd;
    morx_memwr_t mw;
    logic        mie;
  } morx_note_t;
  logic        clk = 1'b0;    // Core clock
  logic        rst_n = 1'b0;  // Reset, low
  logic        vld = 1'b0;    // Issue strobe
  morx_instr_t ins = '0;      // Instruction
  logic [7:0]  mem = 8'h00;   // Memory byte
  logic [10:0] top = 11'h000; // Stack top
  logic        irq = 1'b0;    // Pending request
  logic        clr = 1'b0;    // Enable clear
  wire  [7:0]  acc;
  wire         zero, pop, push, mie;
  wire  [10:0] pc, pd;
  morx_memwr_t mw;
  morx_note_t  exp_q[$];      // Notes awaiting results
  morx_note_t  m;             // Running model state
  logic        bub = 1'b0;    // Model bubble after vectoring
  int          fails = 0;
  int          cmp_count = 0;
  integer      seed = 32'h8dda;
  integer      r;
  always #5 clk = ~clk;
  morx_exec dut_u (.CLK(clk), .RESETN(rst_n), .INSTR_VALID(vld), .INSTR(ins), .MEM_RDATA(mem), .STACK_TOP(top),
    .IRQ_PENDING(irq), .IRQ_ENABLE_CLEAR(clr), .ACC(acc), .ZERO(zero), .PC(pc), .STACK_POP(pop), .STACK_PUSH(push),
    .PUSH_DATA(pd), .MEM_WR(mw), .MASTER_IRQ_ENABLE(mie));
  // One comparison, counted
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Drive one cycle at the falling edge and note what must follow
  task automatic issue(input logic v, input morx_op_t op, input logic [7:0] im, input logic [7:0] mb,
                       input logic [10:0] tp, input logic ir, input logic cl);
    logic [7:0] res;
    @(negedge clk);
    vld = v;
    ins = '{op, im, 7'h2a};
    mem = mb;
    top = tp;
    irq = ir;
    clr = cl;
    m.pop = 0;
    m.push = 0;
    m.mw.we = 0;
    m.mw.addr = 7'h2a;
    if (cl) m.mie = 0;          // Clear acts even in the bubble
    res = m.acc | (op == MORX_OP_OR_IMM ? im : mb);
    if (bub) bub = 0;           // Request refused right after vectoring
    else if (v) begin
      m.pc = m.pc + 11'h001;
      case (op)
        MORX_OP_OR_IMM: begin
          m.acc = res;
          m.zero = (res == 8'h00);
        end
        MORX_OP_OR_TO_MEMORY: begin
          m.mw = '{1'b1, 7'h2a, res};
          m.zero = (res == 8'h00);
        end
        MORX_OP_SUBROUTINE_EXIT: begin
          m.pc = tp;
          m.pop = 1;
        end
        MORX_OP_SUBROUTINE_EXIT_IMM: begin
          m.pc = tp;
          m.pop = 1;
          m.acc = im;
        end
        MORX_OP_INTERRUPT_EXIT: begin
          m.pop = 1;
          if (ir) begin
            m.pc = `MORX_IRQ_VEC;
            m.push = 1;
            m.pd = tp;
            m.mie = 0;
            bub = 1;
          end else begin
            m.pc = tp;
            m.mie = 1;
          end
        end
        MORX_OP_MEMORY_LEFT_ROTATE: m.mw = '{1'b1, 7'h2a, {mb[6:0], mb[7]}};
        MORX_OP_LEFT_ROTATE_TO_WORKING_REG: m.acc = {mb[6:0], mb[7]};
        default: ;
      endcase
    end
    exp_q.push_back(m);
  endtask : issue
  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // Watcher: oldest note against settled outputs
  always @(posedge clk) begin
    morx_note_t e;
    #1;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("acc", 11'(e.acc), 11'(acc));
      chk("zero", 11'(e.zero), 11'(zero));
      chk("pc", e.pc, pc);
      chk("pop", 11'(e.pop), 11'(pop));
      chk("push", 11'(e.push), 11'(push));
      chk("mie", 11'(e.mie), 11'(mie));
      chk("we", 11'(e.mw.we), 11'(mw.we));
      if (e.push) chk("pd", e.pd, pd);
      if (e.mw.we) begin
        chk("waddr", 11'(e.mw.addr), 11'(mw.addr));
        chk("wdata", 11'(e.mw.data), 11'(mw.data));
      end
    end
  end
  // Watchdog against a hang
  initial begin
    #20us;
    fails++;
    complete_run();
  end
  // Main sequence
  initial begin
    m = '{8'h00, 1'b0, 11'h000, 1'b0, 1'b0, 11'h000, '0, 1'b0};
    repeat (10) @(posedge clk);
    @(negedge clk) rst_n = 1;
    issue(1, MORX_OP_OR_IMM, 8'h00, 8'h00, 0, 0, 0);
    issue(1, MORX_OP_OR_TO_MEMORY, 8'h00, 8'h00, 0, 0, 0);
    issue(1, MORX_OP_OR_IMM, 8'h5a, 8'h00, 0, 0, 0);
    issue(1, MORX_OP_OR_TO_MEMORY, 8'h00, 8'h81, 0, 0, 0);
    issue(1, MORX_OP_MEMORY_LEFT_ROTATE, 8'h00, 8'h81, 0, 0, 0);
    issue(1, MORX_OP_LEFT_ROTATE_TO_WORKING_REG, 8'h00, 8'h80, 0, 0, 0);
    issue(1, MORX_OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 11'h7ff, 0, 0);
    issue(1, MORX_OP_SUBROUTINE_EXIT_IMM, 8'h00, 8'h00, 11'h123, 0, 0);
    issue(1, MORX_OP_INTERRUPT_EXIT, 8'h00, 8'h00, 11'h456, 0, 0);
    issue(1, MORX_OP_NONE, 8'h00, 8'h00, 0, 0, 1);
    issue(1, MORX_OP_INTERRUPT_EXIT, 8'h00, 8'h00, 11'h321, 0, 1);
    issue(1, MORX_OP_NONE, 8'h00, 8'h00, 0, 0, 0);
    issue(1, MORX_OP_INTERRUPT_EXIT, 8'h00, 8'h00, 11'h2bc, 1, 0);
    issue(1, MORX_OP_OR_IMM, 8'hff, 8'h00, 0, 0, 0);
    // Random back-to-back traffic, no pending requests
    repeat (60) begin
      r = $random(seed);
      issue(r[3], morx_op_t'(r[6:4]), r[15:8], r[23:16], r[31:21], 0, r[7] & r[2]);
    end
    issue(0, MORX_OP_NONE, 8'h00, 8'h00, 0, 0, 0);
    repeat (3) @(negedge clk);
    complete_run();
  end
endmodule : test_mcu_or_return_rotate_exec
`default_nettype wire
